// [hw/psg_level_track.sv]
`timescale 1ns/1ps
module psg_level_track
	import psg_pkg::*;
#(
	parameter int unsigned N     = NUM_GROUPS,
	parameter int unsigned HOLD  = STATIC_CYC
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [N-1:0] req_i,
	output logic      [N-1:0] rise_o,
	output logic      [N-1:0] static_o
);

	logic [N-1:0] prev_reg;
	logic [N-1:0] prev_next;
	logic [CNT_W-1:0] cnt_reg  [N];
	logic [CNT_W-1:0] cnt_next [N];

	always_comb begin
		prev_next = req_i;
		for (int i = 0; i < N; i++) begin
			if (!req_i[i]) begin
				cnt_next[i] = '0;
			end else if (cnt_reg[i] != CNT_W'(HOLD)) begin
				cnt_next[i] = cnt_reg[i] + 1'b1;
			end else begin
				cnt_next[i] = cnt_reg[i];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			prev_reg <= '0;
			for (int i = 0; i < N; i++) begin
				cnt_reg[i] <= '0;
			end
		end else begin
			prev_reg <= prev_next;
			for (int i = 0; i < N; i++) begin
				cnt_reg[i] <= cnt_next[i];
			end
		end
	end

	generate
		for (genvar g = 0; g < N; g++) begin : g_trk
			assign rise_o[g]   = req_i[g] & ~prev_reg[g]; // [RULE20]
			assign static_o[g] = req_i[g] & (cnt_reg[g] == CNT_W'(HOLD)); // [RULE5]
		end
	endgenerate

endmodule

// [hw/psg_pkg.sv]
package psg_pkg;

	localparam int unsigned NUM_GROUPS = 8;
	localparam int unsigned GRP_W      = 3;
	localparam int unsigned SEL_W      = 4;

	// group one is index zero; selection codes use zero for none
	localparam logic [GRP_W-1:0] GRP_FIRST  = 3'h0;
	localparam logic [SEL_W-1:0] SEL_NONE   = 4'h0;
	localparam logic [GRP_W-1:0] USED_RESET = 3'h0;

	// a request present on STATIC_CYC + 1 consecutive samples counts as a static level
	localparam int unsigned STATIC_NS     = 100;
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned STATIC_CYC    = (STATIC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W         = 8;

	typedef struct packed {
		logic       override_enable;
		logic [SEL_W-1:0] force_sel;
		logic [GRP_W-1:0] used_last;
		logic [SEL_W-1:0] remote_sel;
	} psg_cfg_s;

	typedef struct packed {
		logic fail_not_configured;
		logic fail_lower_priority;
		logic fail_force;
	} psg_fail_s;

	typedef enum logic [1:0] {
		PSG_IDLE,
		PSG_AUTO,
		PSG_FORCED
	} psg_mode_e;

endpackage

// [hw/psg_selector.sv]
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] up to eight groups, exactly one shown active at all times
// [RULE2] after reset only group one is used and active; selection idle
// [RULE3] with more than one group used, inputs decide the active group
// [RULE4] override enable set: automatic inputs ignored, only forced group applied
// [RULE5] every input works both as a pulse and as a static level
// [RULE6] simultaneous requests: lowest-numbered group wins
// [RULE7] pulse-chosen group stays until another group's request is accepted
// [RULE8] forced change only with override enabled and target group in use
// [RULE9] override cleared with static levels present: resume priority selection at once
// [RULE10] force selection none or one to eight, acts as latched pulse
// [RULE11] after override release with no requests, last forced group stays
// [RULE12] other party sets override enable before forcing; stays until cleared
// [RULE13] used groups one to N, reset one; new groups start from defaults
// [RULE14] remote request rejected while a higher-priority group held by level
// [RULE15] active group readable, coded one to eight, group one after reset; active_group_o codes it zero to seven
// [RULE16] static level on group one blocks all other requests
// [RULE17] static level on groups two to seven blocks all lower groups
// [RULE18] static level on group eight blocks nothing
// [RULE19] fail flags for unconfigured target and for lower-priority rejection
// [RULE20] pulses seen on rising edge; inputs sampled every clock
module psg_selector
	import psg_pkg::*;
#(
	parameter int unsigned N = NUM_GROUPS
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [N-1:0]     group_req_i,
	input  wire psg_cfg_s         cfg_i,
	output logic      [GRP_W-1:0] active_group_o,
	output logic      [N-1:0]     active_onehot_o,
	output logic      [N-1:0]     used_mask_o,
	output logic      [N-1:0]     load_defaults_o,
	output psg_fail_s             fail_o,
	output psg_mode_e             mode_o
);

	// first-in-priority index of a vector; lowest bit is highest priority
	function automatic logic [GRP_W-1:0] first_set(input logic [N-1:0] v);
		logic [GRP_W-1:0] r;
		r = GRP_FIRST;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = GRP_W'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [N-1:0] mask_upto(input logic [GRP_W-1:0] last);
		logic [N-1:0] m;
		m = '0;
		for (int i = 0; i < N; i++) begin
			m[i] = (GRP_W'(i) <= last);
		end
		return m;
	endfunction

	// pins from digital inputs: two-stage synchroniser
	logic [N-1:0] sync1_reg;
	logic [N-1:0] sync2_reg;
	logic [N-1:0] rise;
	logic [N-1:0] lvl;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= group_req_i;
			sync2_reg <= sync1_reg;
		end
	end

	psg_level_track #(
		.N    (N),
		.HOLD (STATIC_CYC)
	) u_trk (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_i),
		.req_i    (sync2_reg),
		.rise_o   (rise),
		.static_o (lvl)
	);

	logic [GRP_W-1:0] active_reg, active_next;
	logic [N-1:0]     used_reg, used_next;
	logic [N-1:0]     defl_reg, defl_next;
	logic [SEL_W-1:0] force_prev_reg, force_prev_next;
	logic [SEL_W-1:0] remote_prev_reg, remote_prev_next;
	logic             ovr_prev_reg, ovr_prev_next;
	psg_fail_s        fail_reg, fail_next;
	psg_mode_e        mode_reg, mode_next;

	// locals for the selection
	logic [N-1:0]     blocked;
	logic [N-1:0]     lvl_up;
	logic [N-1:0]     accept;
	logic [N-1:0]     cand;
	logic [GRP_W-1:0] hold_grp;
	logic             any_static;
	logic             force_new;
	logic             remote_new;
	logic [GRP_W-1:0] force_grp;
	logic [GRP_W-1:0] remote_grp;

	always_comb begin
		used_next        = mask_upto(cfg_i.used_last); // [RULE13]
		defl_next        = used_next & ~used_reg; // [RULE13]
		force_prev_next  = cfg_i.force_sel;
		remote_prev_next = cfg_i.remote_sel;
		ovr_prev_next    = cfg_i.override_enable;
		active_next      = active_reg;
		fail_next        = '0;
		mode_next        = mode_reg;
		force_grp        = GRP_W'(cfg_i.force_sel - 1'b1);
		remote_grp       = GRP_W'(cfg_i.remote_sel - 1'b1);
		force_new        = (cfg_i.force_sel != SEL_NONE) && (cfg_i.force_sel != force_prev_reg);
		remote_new       = (cfg_i.remote_sel != SEL_NONE) && (cfg_i.remote_sel != remote_prev_reg);
		any_static       = |(lvl & used_reg);
		hold_grp         = first_set(lvl & used_reg);
		// a level blocks every group below it; group eight has none below
		blocked = '0;
		for (int i = 1; i < N; i++) begin
			blocked[i] = blocked[i-1] | (lvl[i-1] & used_reg[i-1]); // [RULE16] [RULE17] [RULE18]
		end
		// a lower-priority level must not unseat a group that a pulse chose
		for (int i = 0; i < N; i++) begin
			lvl_up[i] = (GRP_W'(i) < active_reg); // [RULE7]
		end
		accept = (rise | (lvl & lvl_up)) & used_reg & ~blocked; // [RULE5]
		cand   = accept;
		if (used_reg == mask_upto(USED_RESET)) begin
			mode_next   = PSG_IDLE;
			active_next = GRP_FIRST; // [RULE2]
			if ((rise & ~used_reg) != '0) begin
				fail_next.fail_not_configured = 1'b1; // [RULE19]
			end
		end else if (cfg_i.override_enable) begin
			mode_next = PSG_FORCED; // [RULE4]
			if (force_new) begin
				if (used_reg[force_grp]) begin
					active_next = force_grp; // [RULE8] [RULE10]
				end else begin
					fail_next.fail_not_configured = 1'b1; // [RULE19]
				end
			end
		end else begin
			mode_next = PSG_AUTO; // [RULE3]
			if (remote_new) begin
				if (!used_reg[remote_grp]) begin
					fail_next.fail_not_configured = 1'b1; // [RULE19]
				end else if (blocked[remote_grp]) begin
					fail_next.fail_lower_priority = 1'b1; // [RULE14] [RULE19]
				end else begin
					cand[remote_grp] = 1'b1;
				end
			end
			if ((rise & ~used_reg) != '0) begin
				fail_next.fail_not_configured = 1'b1; // [RULE19]
			end
			if ((rise & used_reg & blocked) != '0) begin
				fail_next.fail_lower_priority = 1'b1; // [RULE19]
			end
			if (cand != '0) begin
				active_next = first_set(cand); // [RULE6] [RULE7] [RULE9]
			end else if (any_static && ovr_prev_reg) begin
				active_next = hold_grp; // [RULE9]
			end
			// no request keeps the forced group in place [RULE11]
		end
		// forcing while override is off is refused
		if (!cfg_i.override_enable && force_new) begin
			fail_next.fail_force = 1'b1; // [RULE8]
		end
		if (!used_next[active_next]) begin
			active_next = GRP_FIRST; // [RULE1]
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			active_reg      <= GRP_FIRST; // [RULE15]
			used_reg        <= mask_upto(USED_RESET);
			defl_reg        <= '0;
			force_prev_reg  <= SEL_NONE; // [RULE10]
			remote_prev_reg <= SEL_NONE;
			ovr_prev_reg    <= 1'b0;
			fail_reg        <= '0;
			mode_reg        <= PSG_IDLE;
		end else begin
			active_reg      <= active_next;
			used_reg        <= used_next;
			defl_reg        <= defl_next;
			force_prev_reg  <= force_prev_next;
			remote_prev_reg <= remote_prev_next;
			ovr_prev_reg    <= ovr_prev_next;
			fail_reg        <= fail_next;
			mode_reg        <= mode_next;
		end
	end

	logic [N-1:0] onehot_reg;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			onehot_reg <= N'(1);
		end else begin
			onehot_reg <= N'(1) << active_next; // [RULE1]
		end
	end

	assign active_group_o  = active_reg; // [RULE15]
	assign active_onehot_o = onehot_reg;
	assign used_mask_o     = used_reg;
	assign load_defaults_o = defl_reg;
	assign fail_o          = fail_reg;
	assign mode_o          = mode_reg;

	onehot_act_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE1]
		$onehot(onehot_reg) && onehot_reg[active_reg])
		else $error("active group indication not one-hot");

	idle_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE2]
		(mode_reg == PSG_IDLE) |-> (active_reg == GRP_FIRST))
		else $error("idle selector not on group one");

	active_used_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE13]
		used_reg[active_reg])
		else $error("active group not in use");

	forced_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE4]
		(cfg_i.override_enable && ovr_prev_reg && mode_reg == PSG_FORCED && !force_new
		 && $stable(used_reg)) |=> $stable(active_reg))
		else $error("active group moved under override");

	sequence s_lvl_one;
		lvl[0] && used_reg[0] && !cfg_i.override_enable;
	endsequence

	lvl_one_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE16]
		s_lvl_one ##0 (mode_reg != PSG_IDLE) |=> (active_reg == GRP_FIRST))
		else $error("group one level did not hold");

	pri_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE6]
		(mode_next == PSG_AUTO && cand != '0 && used_next[first_set(cand)])
		|=> (active_reg == $past(first_set(cand))))
		else $error("lowest requested group not taken");

	rej_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE19]
		(mode_next == PSG_AUTO && (rise & used_reg & blocked) != '0)
		|=> fail_reg.fail_lower_priority)
		else $error("lower priority rejection not flagged");

	bad_force_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE8]
		(mode_next == PSG_FORCED && force_new && !used_reg[force_grp])
		|=> (fail_reg.fail_not_configured && active_reg == $past(active_reg)))
		else $error("force to unused group not refused");

	pulse_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE7]
		(mode_next == PSG_AUTO && cand == '0 && !any_static && !remote_new
		 && used_next[active_reg]) |=> $stable(active_reg))
		else $error("pulse-selected group lost");

	force_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE8]
		(!cfg_i.override_enable && force_new) |=> fail_reg.fail_force)
		else $error("force without override not flagged");

	dflt_used_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE13]
		(defl_reg & ~used_reg) == '0)
		else $error("defaults loaded for unused group");

	blk_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE17]
		(mode_next == PSG_AUTO && any_static && used_next == used_reg)
		|=> (active_reg <= $past(hold_grp)))
		else $error("group below a static level taken");

	// release with levels present and nothing else asking
	sequence s_release;
		mode_next == PSG_AUTO && ovr_prev_reg && any_static && rise == '0 && !remote_new;
	endsequence

	resume_lvl_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE9]
		s_release ##0 (used_next == used_reg) |=> (active_reg == $past(hold_grp)))
		else $error("levels not resumed after override release");

	cfg_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE19]
		(!cfg_i.override_enable && (rise & ~used_reg) != '0)
		|=> fail_reg.fail_not_configured)
		else $error("request for unused group not flagged");

endmodule

// [testbench/psg_selector_bench.sv]
`timescale 1ns/1ps
module psg_selector_bench;
	import psg_pkg::*;
	logic       clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [7:0] req;
	psg_cfg_s   cfg = '0;
	logic [2:0] act;
	logic [7:0] onehot;
	logic [7:0] used;
	psg_fail_s  fail;
	psg_fail_s  seen = '0;
	logic [7:0] dflt;
	logic [7:0] dflt_seen = '0;
	psg_mode_e  mode;
	int         mismatches = 0;
	int         compares = 0;
	int         cyc = 0;
	psg_source u_src (.clk_i(clk_i), .req_o(req));
	psg_selector u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .group_req_i(req), .cfg_i(cfg),
		.active_group_o(act), .active_onehot_o(onehot), .used_mask_o(used),
		.load_defaults_o(dflt), .fail_o(fail), .mode_o(mode));
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	// fail flags are one-cycle pulses; keep them until the sequence looks
	always @(posedge clk_i) begin
		seen <= seen | fail;
		dflt_seen <= dflt_seen | dflt;
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic clr;
		#1 seen = '0;
		@(posedge clk_i);
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		tick(2);
		rst_n_i <= 1'b1;
		tick(2);
		chk("active", 8'h00, 8'(act));
		chk("onehot", 8'h01, onehot);
		chk("used", 8'h01, used);
		chk("mode", 8'(PSG_IDLE), 8'(mode));
		clr();
		u_src.pulse(8'h04);
		tick(6);
		chk("active", 8'h00, 8'(act));
		chk("fail", 8'h04, 8'(seen));
		$display("test reset done");
		cfg.used_last <= 3'h7;
		tick(2);
		chk("used", 8'hff, used);
		u_src.pulse(8'h04);
		tick(6);
		chk("active", 8'h02, 8'(act));
		chk("defaults", 8'hfe, dflt_seen);
		tick(10);
		chk("active", 8'h02, 8'(act));
		u_src.pulse(8'h12);
		tick(6);
		chk("active", 8'h01, 8'(act));
		$display("test pulses done");
		u_src.hold(8'h04);
		tick(12);
		chk("active", 8'h02, 8'(act));
		clr();
		u_src.pulse(8'h10);
		tick(6);
		chk("active", 8'h02, 8'(act));
		chk("fail", 8'h02, 8'(seen));
		cfg.remote_sel <= 4'h6;
		tick(4);
		chk("active", 8'h02, 8'(act));
		u_src.hold(8'h80);
		tick(12);
		chk("active", 8'h07, 8'(act));
		u_src.pulse(8'h08);
		tick(6);
		chk("active", 8'h03, 8'(act));
		u_src.hold(8'h01);
		tick(12);
		u_src.pulse(8'h02);
		tick(6);
		chk("active", 8'h00, 8'(act));
		u_src.hold(8'h00);
		$display("test levels done");
		cfg.override_enable <= 1'b1;
		tick(2);
		cfg.force_sel <= 4'h6;
		tick(3);
		chk("active", 8'h05, 8'(act));
		chk("mode", 8'(PSG_FORCED), 8'(mode));
		u_src.pulse(8'h01);
		u_src.hold(8'h02);
		tick(12);
		chk("active", 8'h05, 8'(act));
		cfg.override_enable <= 1'b0;
		tick(3);
		chk("active", 8'h01, 8'(act));
		u_src.hold(8'h00);
		cfg.force_sel <= 4'h0;
		cfg.override_enable <= 1'b1;
		tick(2);
		cfg.force_sel <= 4'h4;
		tick(3);
		cfg.override_enable <= 1'b0;
		tick(10);
		chk("active", 8'h03, 8'(act));
		clr();
		cfg.force_sel <= 4'h0;
		tick(2);
		cfg.force_sel <= 4'h2;
		tick(3);
		chk("active", 8'h03, 8'(act));
		chk("fail", 8'h01, 8'(seen));
		$display("test force done");
		cfg.used_last <= 3'h1;
		cfg.remote_sel <= 4'h0;
		tick(3);
		chk("active", 8'h00, 8'(act));
		clr();
		cfg.remote_sel <= 4'h5;
		tick(3);
		chk("fail", 8'h04, 8'(seen));
		cfg.remote_sel <= 4'h0;
		tick(2);
		cfg.remote_sel <= 4'h2;
		tick(3);
		chk("active", 8'h01, 8'(act));
		chk("onehot", 8'h02, onehot);
		clr();
		cfg.override_enable <= 1'b1;
		cfg.force_sel <= 4'h0;
		tick(2);
		cfg.force_sel <= 4'h7;
		tick(3);
		chk("active", 8'h01, 8'(act));
		chk("fail", 8'h04, 8'(seen));
		$display("test remote done");
		print_verdict();
	end
endmodule

// [testbench/psg_source.sv]
`timescale 1ns/1ps
module psg_source (
	input  wire logic       clk_i,
	output logic      [7:0] req_o
);
	logic [7:0] level_reg = 8'h00;
	logic [7:0] pulse_reg = 8'h00;
	// one clock only, so a pulse can never count as a static level
	task automatic pulse(input logic [7:0] m);
		pulse_reg <= m;
		@(posedge clk_i);
		pulse_reg <= 8'h00;
	endtask
	task automatic hold(input logic [7:0] m);
		level_reg <= m;
	endtask
	assign req_o = level_reg | pulse_reg;
endmodule
